// ---- pll_cal_pkg.sv ----
/*
 * constants, state codes and carrier types for the synthesizer calibration control.
 * assumes the register port decoder and the radio state machine run on clk_i at 100 MHz.
 */
package pll_cal_pkg;

   // =========================================================================
   // register offsets and reset values
   // =========================================================================
   localparam logic [5:0] CHANNEL_CCA_OFS   = 6'h08;
   localparam logic [5:0] FILTER_TUNE_OFS   = 6'h18;
   localparam logic [5:0] CF_CAL_OFS        = 6'h1A;
   localparam logic [5:0] DELAY_CAL_OFS     = 6'h1B;

   localparam int         START_BIT         = 7;
   localparam int         ASSESS_TRIG_BIT   = 7;
   localparam int         ASSESS_SEL_LSB    = 5;
   localparam int         CHANNEL_MSB       = 4;
   localparam int         VCO_WORD_MSB      = 3;

   localparam logic [7:0] CHANNEL_CCA_RST   = 8'h2B;
   localparam logic [6:0] FILTER_TUNE_RST   = 7'h58;
   localparam logic [6:0] CF_CAL_RST        = 7'h57;
   localparam logic [5:0] DELAY_CAL_RST     = 6'h20;
   localparam logic [4:0] CHANNEL_FIRST     = 5'h0B;
   localparam logic [4:0] CHANNEL_LAST      = 5'h1A;
   localparam logic [7:0] UNMAPPED_DATA     = 8'h00;

   // =========================================================================
   // timing
   // =========================================================================
   localparam int CLK_PERIOD_NS    = 10;
   localparam int CF_CAL_US        = 8;
   localparam int DELAY_CAL_US     = 6;
   localparam int FILTER_TUNE_US   = 25;
   localparam int TX_RX_SETTLE_US  = 32;
   localparam int CF_CAL_CYCLES    = (CF_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_CAL_CYCLES = (DELAY_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FILTER_CYCLES    = (FILTER_TUNE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_CYCLES    = (TX_RX_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // =========================================================================
   // radio states and carriers
   // =========================================================================
   typedef enum logic [3:0] {
      power_on_state   = 4'h0,
      radio_off_state  = 4'h1,
      synth_on_state   = 4'h3,
      listen_state     = 4'h2,
      busy_tx_state    = 4'h6,
      tx_retry_state   = 4'h7,
      rx_autoack_state = 4'h5,
      sleep_state      = 4'h4,
      reset_state      = 4'hC
   } trx_state_e;

   typedef struct packed {
      logic       we;
      logic       re;
      logic [5:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

   typedef struct packed {
      logic cf;
      logic delay_cell_unit;
      logic filter_tuning;
   } cal_busy_s;

endpackage

// ---- pll_calibration_control.sv ----
/*
 * synthesizer calibration control: channel register, calibration start bits with
 * cycle timers, filter tuning, and the lock / unlock interrupt flags.
 * assumes reg_req_i and trx_state_i come from logic on clk_i; pll_unlock_i is asynchronous.
 */
// Function
// RULE1: host requests manual CF or delay calibration only in synth-on or listen state.
// RULE2: completed center-frequency tuning raises the locked interrupt.
// RULE3: CF and delay-cell calibrations can start together and run concurrently.
// RULE4: host should recalibrate after five minutes on a channel or temperature change.
// RULE5: lock raises interrupt 0, unexpected loss of lock raises interrupt 1.
// RULE6: raising either lock interrupt clears the other pending one.
// RULE7: locked interrupt on leaving radio-off or channel change in four active states.
// RULE8: host treats unexpected synthesizer interrupts as errors and reads device state.
// RULE9: return from transmit to synth-on raises no locked interrupt while settling.
// RULE10: five-bit channel 0x0B to 0x1A, others reserved, reset 0x0B.
// RULE11: CF start bit runs an 8 us cycle and clears itself when done.
// RULE12: low four bits of CF register hold the VCO start word, reset 0x7.
// RULE13: delay-cell start bit runs a 6 us cycle and clears itself when done.
// RULE14: filter tuning starts automatically entering radio-off from power-on, sleep, reset.
// RULE15: filter start bit runs a 25 us cycle and clears itself when done.
// RULE16: host should retune filter manually at most five minutes apart, in allowed states.
// RULE17: channel register also holds assess trigger bit 7 and assess select bits 6:5.
// RULE18: leaving radio-off runs both loops; channel change reruns CF calibration.
// RULE19: retuning steps around a transmission raise neither lock interrupt.
// RULE20: each cycle is timed by a reference-clock counter that clears its start bit.
// RULE21: a start bit written in a disallowed state starts no cycle.

// =============================================================================
// calibration cycle timer
// =============================================================================
module cal_timer #(
   parameter int unsigned CYCLES = 8
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic start_i,
   output logic      busy_o,
   output logic      done_o
);
   localparam int W = $clog2(CYCLES);

   logic [W-1:0] cnt_reg;
   logic [W-1:0] cnt_next;
   logic         busy_reg;
   logic         busy_next;
   logic         done_reg;
   logic         done_next;

   always_comb begin
      cnt_next  = cnt_reg;
      busy_next = busy_reg;
      done_next = 1'b0;
      if (start_i) begin
         cnt_next  = W'(CYCLES - 1);
         busy_next = 1'b1;
      end else if (busy_reg) begin
         if (cnt_reg == '0) begin
            busy_next = 1'b0; // RULE20
            done_next = 1'b1;
         end else begin
            cnt_next = cnt_reg - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
      end
   end

   assign busy_o = busy_reg;
   assign done_o = done_reg;
endmodule // cal_timer

// =============================================================================
// top
// =============================================================================
module pll_calibration_control import pll_cal_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire reg_req_s   reg_req_i,
   input  wire trx_state_e trx_state_i,
   input  wire logic       pll_unlock_i,
   output logic [7:0]      reg_rdata_o,
   output logic [4:0]      channel_o,
   output logic [3:0]      vco_center_word_o,
   output logic            assess_trigger_o,
   output logic [1:0]      assess_select_o,
   output cal_busy_s       cal_busy_o,
   output logic            lock_irq_o,
   output logic            unlock_irq_o
);

   // ==========================================================================
   // state decode
   // ==========================================================================
   trx_state_e state_prev_reg;
   logic       in_active;
   logic       prev_active;
   logic       manual_ok;
   logic       filter_ok;

   always_comb begin
      in_active   = trx_state_i inside {synth_on_state, listen_state,
                                        tx_retry_state, rx_autoack_state};
      prev_active = state_prev_reg inside {synth_on_state, listen_state,
                                           tx_retry_state, rx_autoack_state};
      manual_ok   = trx_state_i inside {synth_on_state, listen_state}; // RULE1
      filter_ok   = trx_state_i inside {radio_off_state, synth_on_state, listen_state};
   end

   // ==========================================================================
   // registers
   // ==========================================================================
   logic [7:0] chan_reg;
   logic [7:0] chan_next;
   logic [6:0] ftn_reg;
   logic [6:0] ftn_next;
   logic [6:0] cf_reg;
   logic [6:0] cf_next;
   logic [5:0] dcu_reg;
   logic [5:0] dcu_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic       wr_chan;
   logic       chan_change;
   logic       cf_go;
   logic       dcu_go;
   logic       ftn_go;
   logic       auto_both;
   logic       auto_ftn;
   logic       cf_busy;
   logic       dcu_busy;
   logic       ftn_busy;
   logic       cf_done;
   logic       settle_busy;

   always_comb begin
      chan_next  = chan_reg;
      ftn_next   = ftn_reg;
      cf_next    = cf_reg;
      dcu_next   = dcu_reg;
      rdata_next = rdata_reg;
      wr_chan    = reg_req_i.we && (reg_req_i.addr == CHANNEL_CCA_OFS);
      chan_change = 1'b0;
      if (wr_chan) begin
         chan_next[7:CHANNEL_MSB+1] = reg_req_i.wdata[7:CHANNEL_MSB+1]; // RULE17
         if ((reg_req_i.wdata[CHANNEL_MSB:0] >= CHANNEL_FIRST) &&
             (reg_req_i.wdata[CHANNEL_MSB:0] <= CHANNEL_LAST)) begin
            chan_next[CHANNEL_MSB:0] = reg_req_i.wdata[CHANNEL_MSB:0]; // RULE10
            chan_change = reg_req_i.wdata[CHANNEL_MSB:0] != chan_reg[CHANNEL_MSB:0];
         end
      end
      if (reg_req_i.we && (reg_req_i.addr == FILTER_TUNE_OFS)) begin
         ftn_next = reg_req_i.wdata[6:0];
      end
      if (reg_req_i.we && (reg_req_i.addr == CF_CAL_OFS)) begin
         cf_next = reg_req_i.wdata[6:0]; // RULE12
      end
      if (reg_req_i.we && (reg_req_i.addr == DELAY_CAL_OFS)) begin
         dcu_next = reg_req_i.wdata[5:0];
      end
      // manual starts honoured only in the permitted states
      auto_both = in_active && (state_prev_reg == radio_off_state); // RULE18
      auto_ftn  = (trx_state_i == radio_off_state) &&
                  (state_prev_reg inside {power_on_state, sleep_state, reset_state}); // RULE14
      cf_go  = (reg_req_i.we && (reg_req_i.addr == CF_CAL_OFS) &&
                reg_req_i.wdata[START_BIT] && manual_ok) ||
               auto_both || (chan_change && in_active); // RULE21
      dcu_go = (reg_req_i.we && (reg_req_i.addr == DELAY_CAL_OFS) &&
                reg_req_i.wdata[START_BIT] && manual_ok) || auto_both; // RULE3
      ftn_go = (reg_req_i.we && (reg_req_i.addr == FILTER_TUNE_OFS) &&
                reg_req_i.wdata[START_BIT] && filter_ok) || auto_ftn;
      if (reg_req_i.re) begin
         case (reg_req_i.addr)
            CHANNEL_CCA_OFS: rdata_next = chan_reg;
            FILTER_TUNE_OFS: rdata_next = {ftn_busy, ftn_reg};
            CF_CAL_OFS:      rdata_next = {cf_busy, cf_reg}; // RULE11
            DELAY_CAL_OFS:   rdata_next = {dcu_busy, 1'b0, dcu_reg}; // RULE13
            default:         rdata_next = UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         chan_reg       <= CHANNEL_CCA_RST;
         ftn_reg        <= FILTER_TUNE_RST;
         cf_reg         <= CF_CAL_RST;
         dcu_reg        <= DELAY_CAL_RST;
         rdata_reg      <= UNMAPPED_DATA;
         state_prev_reg <= power_on_state;
      end else begin
         chan_reg       <= chan_next;
         ftn_reg        <= ftn_next;
         cf_reg         <= cf_next;
         dcu_reg        <= dcu_next;
         rdata_reg      <= rdata_next;
         state_prev_reg <= trx_state_i;
      end
   end

   // ==========================================================================
   // cycle timers
   // ==========================================================================
   cal_timer #(.CYCLES(CF_CAL_CYCLES)) u_cf_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (cf_go),
      .busy_o  (cf_busy),
      .done_o  (cf_done)
   ); // RULE11

   cal_timer #(.CYCLES(DELAY_CAL_CYCLES)) u_dcu_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (dcu_go),
      .busy_o  (dcu_busy),
      .done_o  ()
   ); // RULE13

   cal_timer #(.CYCLES(FILTER_CYCLES)) u_ftn_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (ftn_go),
      .busy_o  (ftn_busy),
      .done_o  ()
   ); // RULE15

   // settling window after a transmission: unlock detection is masked
   cal_timer #(.CYCLES(SETTLE_CYCLES)) u_settle_timer (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (state_prev_reg == busy_tx_state && trx_state_i != busy_tx_state),
      .busy_o  (settle_busy),
      .done_o  ()
   ); // RULE19

   // ==========================================================================
   // lock / unlock interrupt flags
   // ==========================================================================
   logic unl_sync1_reg;
   logic unl_sync2_reg;
   logic unl_old_reg;
   logic lock_reg;
   logic lock_next;
   logic unlock_reg;
   logic unlock_next;
   logic unlock_set;

   always_comb begin
      unlock_set  = unl_sync2_reg && !unl_old_reg && in_active && !cf_busy && !cf_done &&
                    !settle_busy && (trx_state_i != busy_tx_state); // RULE19
      lock_next   = lock_reg;
      unlock_next = unlock_reg;
      if (cf_done) begin
         lock_next   = 1'b1; // RULE2 RULE7 RULE9
         unlock_next = 1'b0; // RULE6
      end else if (unlock_set) begin
         unlock_next = 1'b1; // RULE5
         lock_next   = 1'b0; // RULE6
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         unl_sync1_reg <= 1'b0;
         unl_sync2_reg <= 1'b0;
         unl_old_reg   <= 1'b0;
         lock_reg      <= 1'b0;
         unlock_reg    <= 1'b0;
      end else begin
         unl_sync1_reg <= pll_unlock_i;
         unl_sync2_reg <= unl_sync1_reg;
         unl_old_reg   <= unl_sync2_reg;
         lock_reg      <= lock_next;
         unlock_reg    <= unlock_next;
      end
   end

   assign reg_rdata_o       = rdata_reg;
   assign channel_o         = chan_reg[CHANNEL_MSB:0];
   assign vco_center_word_o = cf_reg[VCO_WORD_MSB:0];
   assign assess_trigger_o  = chan_reg[ASSESS_TRIG_BIT];
   assign assess_select_o   = chan_reg[ASSESS_SEL_LSB+1:ASSESS_SEL_LSB];
   assign cal_busy_o        = '{cf: cf_busy, delay_cell_unit: dcu_busy, filter_tuning: ftn_busy};
   assign lock_irq_o        = lock_reg;
   assign unlock_irq_o      = unlock_reg;

   // ==========================================================================
   // assertions
   // ==========================================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [11:0] len_reg [3];
   logic [2:0]  busy_vec;
   logic [2:0]  go_vec;
   logic        cf_allowed;
   assign busy_vec = {cf_busy, dcu_busy, ftn_busy};
   assign go_vec   = {cf_go, dcu_go, ftn_go};
   assign cf_allowed = manual_ok || auto_both || (chan_change && in_active);

   for (genvar g = 0; g < 3; g++) begin : g_len
      always_ff @(posedge clk_i or posedge rst_i) begin
         if (rst_i) begin
            len_reg[g] <= '0;
         end else if (go_vec[g]) begin
            len_reg[g] <= '0;
         end else if (busy_vec[g]) begin
            len_reg[g] <= len_reg[g] + 1'b1;
         end
      end
   end

   sequence tx_exit_s;
      trx_state_i == busy_tx_state ##1 trx_state_i == synth_on_state;
   endsequence

   sequence off_exit_s;
      state_prev_reg == radio_off_state && in_active;
   endsequence

   a_lock_on_done: assert property (cf_done |=> lock_irq_o && !unlock_irq_o) // RULE2
      else $error("cf completion did not raise the locked flag");
   a_mutual_clear: assert property ($rose(unlock_irq_o) |-> !lock_irq_o) // RULE6
      else $error("unlock flag rose with locked flag still set");
   a_unlock_edge: assert property ($rose(unlock_irq_o) |-> $past(unl_sync2_reg)) // RULE5
      else $error("unlock flag rose without a synchronised unlock");
   a_cf_length: assert property ($fell(cf_busy) |-> len_reg[2] == 12'(CF_CAL_CYCLES)) // RULE11
      else $error("cf cycle length wrong");
   a_dcu_length: assert property ($fell(dcu_busy) |-> len_reg[1] == 12'(DELAY_CAL_CYCLES)) // RULE13
      else $error("delay cell cycle length wrong");
   a_ftn_length: assert property ($fell(ftn_busy) |-> len_reg[0] == 12'(FILTER_CYCLES)) // RULE15
      else $error("filter cycle length wrong");
   a_both_run: assert property (off_exit_s |=> cf_busy && dcu_busy) // RULE18
      else $error("leaving radio off did not start both loops");
   a_concurrent_go: assert property (cf_go && dcu_go |=> cf_busy && dcu_busy) // RULE3
      else $error("simultaneous calibration requests not both accepted");
   a_manual_gate: assert property ($rose(cf_busy) |-> $past(cf_allowed)) // RULE21
      else $error("cf calibration started in a disallowed state");
   a_ftn_auto: assert property (auto_ftn |=> ftn_busy) // RULE14
      else $error("filter tuning not started on entering radio off");
   a_channel_range: assert property (channel_o >= CHANNEL_FIRST && channel_o <= CHANNEL_LAST) // RULE10
      else $error("channel code outside the valid range");
   a_chan_retune: assert property (chan_change && in_active |=> cf_busy) // RULE7
      else $error("channel change did not retune");
   a_tx_no_lock: assert property (tx_exit_s |-> !$rose(lock_irq_o) [*3]) // RULE9
      else $error("locked flag raised after transmit return");
   a_tx_no_unlock: assert property ($rose(unlock_irq_o) |->
                     !$past(settle_busy) && $past(trx_state_i) != busy_tx_state) // RULE19
      else $error("unlock flag raised during transmit retuning");

endmodule // pll_calibration_control

// ---- host_model.sv ----
/*
 host side model: register port master for the calibration control.
 assumes callers enter its tasks at a falling edge of clk_i.
*/
module host_model import pll_cal_pkg::*; (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output reg_req_s        req_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial req_o = '0;

   // =========================================================================
   // register access, one strobe cycle then one idle cycle
   // =========================================================================
   // released lines show the inverse of the last value, never a held copy
   task automatic idle();
      req_o <= '{we: 1'b0, re: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
   endtask

   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      req_o <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
      @(negedge clk_i);
      idle();
      @(negedge clk_i);
   endtask

   task automatic rd(input logic [5:0] a, output logic [7:0] d);
      req_o <= '{we: 1'b0, re: 1'b1, addr: a, wdata: ~req_o.wdata};
      @(negedge clk_i);
      idle();
      @(negedge clk_i);
      d = rdata_i;
   endtask
endmodule // host_model

// ---- tb.sv ----
/*
 self-checking bench for the synthesizer calibration control.
 assumes the design package and host_model are compiled first.
*/
module tb import pll_cal_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   logic       clk_i;
   logic       rst_i;
   logic       pll_unlock_i;
   trx_state_e trx_state;
   reg_req_s   reg_req;
   logic [7:0] reg_rdata;
   logic [4:0] channel;
   logic [3:0] vco_word;
   logic       assess_trig;
   logic [1:0] assess_sel;
   cal_busy_s  busy;
   logic       lock_irq;
   logic       unlock_irq;
   int         num_errors = 0;
   int         samples_checked = 0;
   logic [5:0] ofs [5]     = '{6'h08, 6'h18, 6'h1A, 6'h1B, 6'h3F};
   logic [7:0] rst_val [5] = '{8'h2B, 8'h58, 8'h57, 8'h20, 8'h00};
   trx_state_e act [4]     = '{synth_on_state, listen_state, tx_retry_state, rx_autoack_state};
   logic [4:0] corner [4]  = '{5'h0A, 5'h0B, 5'h1A, 5'h1B};

   pll_calibration_control pll_calibration_control_i (
      .clk_i(clk_i), .rst_i(rst_i), .reg_req_i(reg_req), .trx_state_i(trx_state),
      .pll_unlock_i(pll_unlock_i), .reg_rdata_o(reg_rdata), .channel_o(channel),
      .vco_center_word_o(vco_word), .assess_trigger_o(assess_trig),
      .assess_select_o(assess_sel), .cal_busy_o(busy), .lock_irq_o(lock_irq),
      .unlock_irq_o(unlock_irq));

   host_model host_model_i (.clk_i(clk_i), .rdata_i(reg_rdata), .req_o(reg_req));

   // =========================================================================
   // helpers
   // =========================================================================
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // counts busy cycles of each loop until all are idle
   task automatic run_len(output int nc, output int nd, output int nf);
      int n;
      nc = 0;
      nd = 0;
      nf = 0;
      n = 0;
      while (busy !== 3'b000 && n < 3000) begin
         nc += int'(busy.cf === 1'b1);
         nd += int'(busy.delay_cell_unit === 1'b1);
         nf += int'(busy.filter_tuning === 1'b1);
         n++;
         @(negedge clk_i);
      end
      check(16'(busy), 16'h0000);
   endtask

   task automatic pulse();
      pll_unlock_i <= 1'b1;
      tick(3);
      pll_unlock_i <= 1'b0;
      tick(6);
   endtask

   task automatic flags(input logic lk, input logic ul);
      check(16'({lock_irq, unlock_irq}), 16'({lk, ul}));
   endtask

   function automatic logic [4:0] exp_channel(input logic [4:0] old, input logic [4:0] code);
      return (code >= CHANNEL_FIRST && code <= CHANNEL_LAST) ? code : old;
   endfunction

   initial begin
      repeat (90000) @(posedge clk_i);
      num_errors++;
      stop_test();
   end

   // =========================================================================
   // main sequence
   // =========================================================================
   initial begin
      int         nc;
      int         nd;
      int         nf;
      logic [7:0] d;
      logic [7:0] r;
      logic [4:0] old;
      logic [3:0] w;
      void'($urandom(65));
      rst_i = 1'b1;
      pll_unlock_i = 1'b0;
      trx_state = power_on_state;
      tick(8);
      rst_i = 1'b0;
      tick(2);
      check(16'(channel), 16'(CHANNEL_FIRST));
      check(16'(vco_word), 16'h0007);
      check(16'({assess_trig, assess_sel}), 16'h0001);
      check(16'(busy), 16'h0000);
      flags(1'b0, 1'b0);
      for (int i = 0; i < 5; i++) begin
         host_model_i.rd(ofs[i], r);
         check(16'(r), 16'(rst_val[i]));
      end
      trx_state <= radio_off_state;
      tick(1);
      check(16'(busy.filter_tuning), 16'h0001);
      run_len(nc, nd, nf);
      check(16'(nf), 16'(FILTER_CYCLES));
      for (int i = 0; i < 4; i++) begin
         trx_state <= radio_off_state;
         tick(2);
         trx_state <= act[i];
         tick(1);
         check(16'({busy.cf, busy.delay_cell_unit}), 16'h0003);
         run_len(nc, nd, nf);
         check(16'(nc), 16'(CF_CAL_CYCLES));
         check(16'(nd), 16'(DELAY_CAL_CYCLES));
         tick(2);
         flags(1'b1, 1'b0);
         pulse();
         flags(1'b0, 1'b1);
      end
      trx_state <= synth_on_state;
      tick(2);
      run_len(nc, nd, nf);
      // manual recalibration in an allowed state
      for (int i = 0; i < 3; i++) begin
         w = 4'($urandom());
         pulse();
         host_model_i.wr(CF_CAL_OFS, {4'hD, w});
         host_model_i.wr(DELAY_CAL_OFS, 8'hA0);
         check(16'({busy.cf, busy.delay_cell_unit}), 16'h0003);
         host_model_i.rd(CF_CAL_OFS, r);
         check(16'(r), 16'({4'hD, w}));
         check(16'(vco_word), 16'(w));
         run_len(nc, nd, nf);
         host_model_i.rd(CF_CAL_OFS, r);
         check(16'(r), 16'({4'h5, w}));
         tick(2);
         flags(1'b1, 1'b0);
      end
      for (int i = 0; i < 12; i++) begin
         d = 8'($urandom());
         if (i < 4) d[4:0] = corner[i];
         old = channel;
         host_model_i.wr(CHANNEL_CCA_OFS, d);
         tick(2);
         check(16'(channel), 16'(exp_channel(old, d[4:0])));
         check(16'({assess_trig, assess_sel}), 16'(d[7:5]));
         if (exp_channel(old, d[4:0]) !== old) begin
            check(16'(busy.cf), 16'h0001);
         end
         run_len(nc, nd, nf);
         host_model_i.rd(CHANNEL_CCA_OFS, r);
         check(16'(r), 16'({d[7:5], exp_channel(old, d[4:0])}));
      end
      host_model_i.wr(CF_CAL_OFS, 8'h80);
      run_len(nc, nd, nf);
      tick(2);
      flags(1'b1, 1'b0);
      trx_state <= busy_tx_state;
      tick(20);
      pulse();
      flags(1'b1, 1'b0);
      trx_state <= synth_on_state;
      tick(5);
      pulse();
      flags(1'b1, 1'b0);
      tick(3300);
      pulse();
      flags(1'b0, 1'b1);
      trx_state <= busy_tx_state;
      tick(20);
      trx_state <= synth_on_state;
      tick(20);
      flags(1'b0, 1'b1);
      trx_state <= radio_off_state;
      tick(2);
      host_model_i.wr(CF_CAL_OFS, 8'h80);
      host_model_i.wr(DELAY_CAL_OFS, 8'h80);
      tick(2);
      check(16'({busy.cf, busy.delay_cell_unit}), 16'h0000);
      host_model_i.wr(FILTER_TUNE_OFS, 8'h80);
      check(16'(busy.filter_tuning), 16'h0001);
      run_len(nc, nd, nf);
      host_model_i.wr(DELAY_CAL_OFS, 8'h7F);
      host_model_i.rd(DELAY_CAL_OFS, r);
      check(16'(r), 16'h003F);
      host_model_i.wr(FILTER_TUNE_OFS, 8'h7F);
      host_model_i.rd(FILTER_TUNE_OFS, r);
      check(16'(r), 16'h007F);
      host_model_i.wr(CF_CAL_OFS, 8'h7F);
      host_model_i.rd(CF_CAL_OFS, r);
      check(16'({vco_word, r}), 16'h0F7F);
      host_model_i.wr(6'h3F, 8'hFF);
      host_model_i.rd(6'h3F, r);
      check(16'(r), 16'(UNMAPPED_DATA));
      trx_state <= busy_tx_state;
      host_model_i.wr(FILTER_TUNE_OFS, 8'h80);
      tick(2);
      check(16'(busy.filter_tuning), 16'h0000);
      for (int i = 0; i < 2; i++) begin
         trx_state <= (i == 0) ? sleep_state : reset_state;
         tick(2);
         trx_state <= radio_off_state;
         tick(1);
         check(16'(busy.filter_tuning), 16'h0001);
         run_len(nc, nd, nf);
         check(16'(nf), 16'(FILTER_CYCLES));
      end
      stop_test();
   end
endmodule // tb
